// >>> design/wsf_filter.sv
`include "wsf_cfg.svh"
`default_nettype none
module wsf_filter
    import wsf_pkg::*;
(
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // comparator pins
    input  wire logic                   squared_input,
    input  wire logic [3:0]             peak_comp,
    // configuration bits
    input  wire logic                   limited_set,
    input  wire logic                   adapt_select,
    input  wire logic                   hyst_select,
    input  wire logic                   feedback_after_filter,
    input  wire logic                   filter_both_edges,
    input  wire logic                   fixed_filter,
    // outputs
    output var  logic                   filtered_output,
    output var  logic [`WSF_LVL_W-1:0]  hyst_code,
    output var  logic [`WSF_LVL_W-1:0]  peak_level,
    output var  logic [`WSF_WIN_W-1:0]  window_cycles
);
    ////////////////////////////////////////////////////////////////////////////
    logic                  sq_sync;
    logic [3:0]            pk_sync;
    genvar                 gi;

    wsf_sync u_sync_sq (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (squared_input),
        .sync_out (sq_sync)
    );

    // one synchroniser per peak comparator
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pk
            wsf_sync u_sync_pk (
                .ref_clk  (ref_clk),
                .rst      (rst),
                .async_in (peak_comp[gi]),
                .sync_out (pk_sync[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    wsf_state_type         state_reg;
    wsf_state_type         state_next;
    logic [`WSF_WIN_W-1:0] win_reg;
    logic [`WSF_WIN_W-1:0] win_next;
    logic [`WSF_WIN_W-1:0] tmr_reg;
    logic [`WSF_WIN_W-1:0] tmr_next;
    logic [`WSF_PER_W-1:0] per_reg;
    logic [`WSF_PER_W-1:0] per_next;
    logic                  out_reg;
    logic                  out_next;
    logic                  sq_prev_reg;
    logic                  sq_prev_next;
    logic [`WSF_LVL_W-1:0] lvl_reg;
    logic [`WSF_LVL_W-1:0] lvl_next;
    logic [`WSF_LVL_W-1:0] hys_reg;
    logic [`WSF_LVL_W-1:0] hys_next;
    logic [`WSF_WIN_W-1:0] win_cur;
    logic [`WSF_WIN_W-1:0] win_calc;
    logic [`WSF_PER_W-1:0] per_div;
    logic                  adapt_time;
    logic                  tmr_done;
    logic                  fb_sig;
    logic                  fb_edge;
    logic [`WSF_LVL_W-1:0] lvl_now;
    logic [`WSF_LVL_W-1:0] hys_map;

    // limited set keeps adaptive timing only on rising edges and ignores fixed filter
    assign adapt_time = adapt_select;

    always_comb begin
        per_div = per_reg >> `WSF_DIV_SHIFT;
        if (per_div > `WSF_PER_W'(`WSF_TMAX_CYC)) begin
            win_calc = `WSF_WIN_W'(`WSF_TMAX_CYC);
        end else if (per_div < `WSF_PER_W'(`WSF_TMIN_CYC)) begin
            win_calc = `WSF_WIN_W'(`WSF_TMIN_CYC);
        end else begin
            win_calc = per_div[`WSF_WIN_W-1:0];
        end
        if (fixed_filter && !limited_set) begin
            win_cur = `WSF_WIN_W'(`WSF_TFIX_CYC);
        end else if (!adapt_time) begin
            win_cur = `WSF_WIN_W'(`WSF_TMAX_CYC);
        end else begin
            win_cur = win_reg;
        end
    end

    assign tmr_done = (tmr_reg >= win_cur - `WSF_WIN_W'(1));

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next   = state_reg;
        tmr_next     = tmr_reg;
        out_next     = out_reg;
        win_next     = win_reg;
        sq_prev_next = sq_sync;
        // period counter saturates at the maximum-window equivalent
        if (per_reg < `WSF_PER_W'(`WSF_TMAX_CYC << `WSF_DIV_SHIFT)) begin
            per_next = per_reg + `WSF_PER_W'(1);
        end else begin
            per_next = per_reg;
        end
        case (state_reg)
            WSF_LOW: begin
                if (sq_sync) begin
                    state_next = WSF_QUALIFY;
                    tmr_next   = '0;
                end
            end
            WSF_QUALIFY: begin
                if (!sq_sync) begin
                    state_next = WSF_LOW;
                end else if (tmr_done) begin
                    state_next = WSF_HIGH;
                    out_next   = 1'b1;
                    win_next   = win_calc;
                    // the qualifying edge cycle already belongs to the next period
                    per_next   = `WSF_PER_W'(1);
                end else begin
                    tmr_next = tmr_reg + `WSF_WIN_W'(1);
                end
            end
            WSF_HIGH: begin
                if (!sq_sync) begin
                    out_next = 1'b0;
                    tmr_next = '0;
                    if (filter_both_edges && !limited_set) begin
                        state_next = WSF_MASK;
                    end else begin
                        state_next = WSF_LOW;
                    end
                end
            end
            WSF_MASK: begin
                // input is looked at only when the mask times out, so bounces before that are dropped
                if (tmr_done) begin
                    state_next = sq_sync ? WSF_QUALIFY : WSF_LOW;
                    tmr_next   = '0;
                end else begin
                    tmr_next = tmr_reg + `WSF_WIN_W'(1);
                end
            end
            default: begin
                state_next = WSF_LOW;
                out_next   = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // thermometer comparators to a level code
    always_comb begin
        lvl_now = `WSF_HYST_1;
        if (pk_sync[0]) lvl_now = `WSF_HYST_2;
        if (pk_sync[1]) lvl_now = `WSF_HYST_3;
        if (pk_sync[2]) lvl_now = `WSF_HYST_4;
        if (pk_sync[3]) lvl_now = `WSF_HYST_5;
        hys_map = lvl_reg;
        fb_sig  = feedback_after_filter ? out_next : sq_sync;
        fb_edge = fb_sig && !(feedback_after_filter ? out_reg : sq_prev_reg);
        lvl_next = lvl_reg;
        if (fb_edge) begin
            lvl_next = lvl_now;
        end
        if (adapt_select) begin
            hys_next = hys_map;
        end else begin
            hys_next = hyst_select ? `WSF_HYST_5 : `WSF_HYST_1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg   <= WSF_LOW;
            win_reg     <= `WSF_WIN_W'(`WSF_TMAX_CYC);
            tmr_reg     <= '0;
            per_reg     <= '0;
            out_reg     <= 1'b0;
            sq_prev_reg <= 1'b0;
            lvl_reg     <= `WSF_HYST_1;
            hys_reg     <= `WSF_HYST_1;
        end else begin
            state_reg   <= state_next;
            win_reg     <= win_next;
            tmr_reg     <= tmr_next;
            per_reg     <= per_next;
            out_reg     <= out_next;
            sq_prev_reg <= sq_prev_next;
            lvl_reg     <= lvl_next;
            hys_reg     <= hys_next;
        end
    end

    assign filtered_output = out_reg;
    assign hyst_code       = hys_reg;
    assign peak_level      = lvl_reg;
    assign window_cycles   = win_reg;
endmodule : wsf_filter
`default_nettype wire

// >>> design/wsf_cfg.svh
`ifndef WSF_CFG_SVH
`define WSF_CFG_SVH
// 40 MHz core clock, period in ps
`define WSF_CLK_PERIOD_PS   25000
// window limits in ns
`define WSF_TMAX_NS         200000
`define WSF_TMIN_NS         4000
`define WSF_TFIX_NS         4000
// window counts in core clock cycles
`define WSF_TMAX_CYC        ((`WSF_TMAX_NS * 1000) / `WSF_CLK_PERIOD_PS)
`define WSF_TMIN_CYC        ((`WSF_TMIN_NS * 1000 + `WSF_CLK_PERIOD_PS - 1) / `WSF_CLK_PERIOD_PS)
`define WSF_TFIX_CYC        ((`WSF_TFIX_NS * 1000) / `WSF_CLK_PERIOD_PS)
// window is the period divided by 32
`define WSF_DIV_SHIFT       5
`define WSF_WIN_W           13
`define WSF_PER_W           18
`define WSF_LVL_W           3
// hysteresis codes
`define WSF_HYST_1          3'h0
`define WSF_HYST_2          3'h1
`define WSF_HYST_3          3'h2
`define WSF_HYST_4          3'h3
`define WSF_HYST_5          3'h4
`endif

// >>> design/wsf_pkg.sv
`default_nettype none
package wsf_pkg;
    typedef enum logic [1:0] {
        WSF_LOW      = 2'h0,
        WSF_QUALIFY  = 2'h1,
        WSF_HIGH     = 2'h2,
        WSF_MASK     = 2'h3
    } wsf_state_type;
endpackage : wsf_pkg
`default_nettype wire

// >>> design/wsf_sync.sv
`include "wsf_cfg.svh"
`default_nettype none
module wsf_sync (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // asynchronous in, synchronised out
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule : wsf_sync
`default_nettype wire

// >>> verification/wsf_sensor.sv
`default_nettype none
module wsf_sensor (
    // clock
    input  wire logic       ref_clk,
    // comparator side
    output var  logic       squared_input,
    output var  logic [3:0] peak_comp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        squared_input = 1'h0;
        peak_comp     = 4'h0;
    end
    // one period of the squared pick-up; the peak may step once, at cycle step_at
    task automatic pulse(input int hi, input int lo, input int step_at, input logic [3:0] pk);
        for (int i = 0; i < hi + lo; i++) begin
            squared_input <= (i < hi);
            if (i == step_at) begin
                peak_comp <= pk;
            end
            @(posedge ref_clk);
            #1;
        end
    endtask : pulse
endmodule : wsf_sensor
`default_nettype wire

// >>> verification/wsf_checker.sv
`include "wsf_cfg.svh"
`default_nettype none
module wsf_checker (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // watched ports
    input  wire logic                  squared_input,
    input  wire logic                  adapt_select,
    input  wire logic                  hyst_select,
    input  wire logic                  filtered_output,
    input  wire logic [`WSF_LVL_W-1:0] hyst_code,
    input  wire logic [`WSF_LVL_W-1:0] peak_level,
    input  wire logic [`WSF_WIN_W-1:0] window_cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_out_rise;
        $rose(filtered_output);
    endsequence
    sequence s_in_fall_high;
        filtered_output && $fell(squared_input);
    endsequence
    AST_RESET_MAX: assert property ($fell(rst) |-> window_cycles == `WSF_TMAX_CYC)
        else $error("window not at maximum after reset");
    AST_WIN_RANGE: assert property (
        window_cycles >= `WSF_TMIN_CYC && window_cycles <= `WSF_TMAX_CYC)
        else $error("window outside its limits");
    AST_WIN_UPDATE: assert property (
        $changed(window_cycles) && !$past(rst) |-> s_out_rise)
        else $error("window changed without an output rise");
    AST_RISE_QUAL: assert property (
        s_out_rise |-> $past(squared_input, 3) && $past(squared_input, 160))
        else $error("output rose without a long enough input high");
    AST_FALL_FOLLOW: assert property (
        $fell(filtered_output) |-> !$past(squared_input, 2))
        else $error("output fell without an input fall");
    // two synchroniser stages plus the output register
    AST_FALL_PASS: assert property (s_in_fall_high |-> ##3 !filtered_output)
        else $error("input fall not passed through");
    AST_PEAK_RANGE: assert property (peak_level <= 3'h4)
        else $error("peak level beyond five levels");
    AST_HYST_ADAPT: assert property (
        (adapt_select && $stable(peak_level)) [*2] |-> hyst_code == peak_level)
        else $error("hysteresis code does not follow peak level");
    AST_HYST_FIXED: assert property ((!adapt_select && $stable(hyst_select)) [*2] |->
        hyst_code == (hyst_select ? 3'h4 : 3'h0))
        else $error("fixed hysteresis code wrong");
endmodule : wsf_checker
bind wsf_filter wsf_checker u_chk (.ref_clk(ref_clk), .rst(rst), .squared_input(squared_input),
    .adapt_select(adapt_select), .hyst_select(hyst_select), .filtered_output(filtered_output),
    .hyst_code(hyst_code), .peak_level(peak_level), .window_cycles(window_cycles));
`default_nettype wire

// >>> verification/tb.sv
`include "wsf_cfg.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  ref_clk = 1'h0, rst = 1'h1, squared_input, filtered_output;
    logic                  limited_set = 1'h0, adapt_select = 1'h1, hyst_select = 1'h0;
    logic                  feedback_after_filter = 1'h0, fixed_filter = 1'h1;
    logic                  filter_both_edges = 1'h0;
    logic [3:0]            peak_comp;
    logic [`WSF_LVL_W-1:0] hyst_code, peak_level;
    logic [`WSF_WIN_W-1:0] window_cycles;
    int                    error_cnt = 0, comparisons = 0, cyc = 0, rd, fd;
    always #12.5 ref_clk = ~ref_clk;
    wsf_sensor sen (.ref_clk(ref_clk), .squared_input(squared_input), .peak_comp(peak_comp));
    wsf_filter uut (.ref_clk(ref_clk), .rst(rst), .squared_input(squared_input),
        .peak_comp(peak_comp), .limited_set(limited_set), .adapt_select(adapt_select),
        .hyst_select(hyst_select), .feedback_after_filter(feedback_after_filter),
        .filter_both_edges(filter_both_edges), .fixed_filter(fixed_filter),
        .filtered_output(filtered_output),
        .hyst_code(hyst_code), .peak_level(peak_level), .window_cycles(window_cycles));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    // rise delay counts edges from the input rise; fall delay from the input fall
    task automatic run(input int hi, input int lo, input int st, input logic [3:0] pk);
        rd = 0;
        fd = 0;
        fork
            sen.pulse(hi, lo, st, pk);
            for (int i = 1; i <= hi + lo; i++) begin
                @(posedge ref_clk);
                #1;
                if (filtered_output === 1'h1 && rd == 0) rd = i;
                if (filtered_output === 1'h0 && rd != 0 && fd == 0) fd = i - hi;
            end
        join
    endtask : run
    task automatic results;
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // a hang ends the run well after the expected 76k cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 95000) begin
            error_cnt++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'h0;
        check(window_cycles, `WSF_TMAX_CYC);
        for (int k = 0; k < 5; k++) begin
            run(1600, 1600, 0, 4'((1 << k) - 1));
            check(rd, `WSF_TFIX_CYC + 3);
            check(fd, 3);
            check(peak_level, k);
            check(hyst_code, k);
        end
        check(window_cycles, `WSF_TMIN_CYC);
        repeat (2) run(3200, 3200, -1, 4'h0);
        check(window_cycles, 6400 / 32);
        $display("test fixed window done");
        fixed_filter = 1'h0;
        run(100, 3100, -1, 4'h0);
        check(rd, 0);
        run(3200, 3200, -1, 4'h0);
        check(rd, 6400 / 32 + 3);
        limited_set = 1'h1;
        fixed_filter = 1'h1;
        run(3200, 3200, -1, 4'h0);
        check(rd, 9640 / 32 + 3);
        $display("test adaptive window done");
        limited_set = 1'h0;
        adapt_select = 1'h0;
        fixed_filter = 1'h0;
        hyst_select = 1'h1;
        run(8200, 200, -1, 4'h0);
        check(rd, `WSF_TMAX_CYC + 3);
        check(hyst_code, 3'h4);
        hyst_select = 1'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        check(hyst_code, 3'h0);
        adapt_select = 1'h1;
        sen.pulse(1, 1, 0, 4'hF);
        // peak steps after the input rise: the latched level shows the feedback point
        for (int j = 0; j < 2; j++) begin
            feedback_after_filter = 1'(j);
            run(3200, 3200, 20, j ? 4'hF : 4'h7);
            check(peak_level, 3'h4);
        end
        $display("test hysteresis done");
        // input comes back high inside the mask: qualification starts only after it
        fixed_filter = 1'h1;
        filter_both_edges = 1'h1;
        run(3200, 10, -1, 4'h0);
        check(fd, 3);
        run(3200, 3200, -1, 4'h0);
        check(rd, 2 * `WSF_TFIX_CYC + 3 - 10);
        $display("test mask done");
        results();
    end
endmodule : tb
`default_nettype wire
